/* fdc_command_decoder.sv */
// floppy command decoder with an ahb-lite register port
`timescale 1ns/1ps
module fdc_command_decoder import fdc_pkg::*; #(
	parameter int SETTLE_CYCLES = FDC_SETTLE_CYCLES,
	parameter int STEP_CYCLES_0 = FDC_STEP_US_0 * FDC_CLK_MHZ,
	parameter int STEP_CYCLES_1 = FDC_STEP_US_1 * FDC_CLK_MHZ,
	parameter int STEP_CYCLES_2 = FDC_STEP_US_2 * FDC_CLK_MHZ,
	parameter int STEP_CYCLES_3 = FDC_STEP_US_3 * FDC_CLK_MHZ
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic drive_ready_in,
	input wire logic index_hole_in,
	input wire logic head_settled_in,
	input wire logic track_zero_n_in,
	input wire logic id_valid_in,
	input wire logic [8:0] id_field_in,
	input wire logic density_select_n,
	output logic head_engage_out,
	output logic inner_track_out,
	output logic step_out,
	output logic direction_out,
	output logic [7:0] data_mark_out,
	output logic byte_request,
	output logic command_irq
);
	logic [1:0] s_ready, s_index, s_settled, s_tr0, s_idv;
	logic ready_q, index_q;
	logic [7:0] cmd, track, sector, data, target, ctrl;
	fdc_state_t state;
	logic [31:0] timer;
	logic [2:0] revs;
	logic [3:0] force_cond;
	logic seek_error, record_missing_flag, boot_restore, stepped;
	logic ph_valid, ph_write;
	logic [31:0] ph_addr;
	fdc_id_t id_s, id_q;

	function automatic fdc_kind_t fdc_decode(input logic [7:0] c);
		if (!c[7]) return FDC_K_POS;
		if (c[6:5] == 2'h0) return FDC_K_RSEC;
		if (c[6:5] == 2'h1) return FDC_K_WSEC;
		if (c[7:4] == 4'hd) return FDC_K_FORCE;
		if (c[3] || c[1:0] != 2'h0) return FDC_K_BAD;
		if (c[7:4] == 4'hc) return FDC_K_RADDR;
		if (c[7:4] == 4'he) return FDC_K_RTRK;
		return FDC_K_WTRK;
	endfunction

	// two-flop synchronisers for drive pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ready <= 2'h0;
			s_index <= 2'h0;
			s_settled <= 2'h0;
			s_tr0 <= 2'h3;
			s_idv <= 2'h0;
			ready_q <= 1'b0;
			index_q <= 1'b0;
			id_s <= '0;
			id_q <= '0;
		end else begin
			s_ready <= {s_ready[0], drive_ready_in};
			s_index <= {s_index[0], index_hole_in};
			s_settled <= {s_settled[0], head_settled_in};
			s_tr0 <= {s_tr0[0], track_zero_n_in};
			s_idv <= {s_idv[0], id_valid_in};
			ready_q <= s_ready[1];
			index_q <= s_index[1];
			id_s <= id_field_in;
			id_q <= id_s;
		end
	end

	wire ready_rise = s_ready[1] && !ready_q;
	wire ready_fall = !s_ready[1] && ready_q;
	wire index_rise = s_index[1] && !index_q;

	// bus address phase
	wire bus_take = hsel && htrans[1] && hready;
	wire [1:0] reg_sel = ph_addr[3:2];
	wire ctrl_hit = ph_addr == FDC_REG_CTRL;
	wire wr_now = ph_valid && ph_write;
	wire rd_now = ph_valid && !ph_write;
	wire cmd_wr = wr_now && !ctrl_hit && reg_sel == FDC_SEL_CMD;
	wire stat_rd = rd_now && !ctrl_hit && reg_sel == FDC_SEL_CMD;
	wire data_acc = ph_valid && !ctrl_hit && reg_sel == FDC_SEL_DATA;
	wire [7:0] wbyte = hwdata[7:0];
	wire fdc_kind_t kind_new = fdc_decode(wbyte);
	wire fdc_kind_t kind = fdc_decode(cmd);
	wire busy = state != FDC_IDLE;
	fdc_status_t status;
	assign status = '{busy: busy, record_missing_flag: record_missing_flag,
		seek_error: seek_error, byte_request: byte_request};
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= '0;
		end else begin
			ph_valid <= bus_take;
			ph_write <= hwrite;
			ph_addr <= haddr;
		end
	end

	// read word captured in the address phase so it stands through the data phase
	wire [1:0] a_sel = haddr[3:2];
	wire a_ctrl = haddr == FDC_REG_CTRL;
	wire [31:0] rd_mux = a_ctrl ? {24'h0, ctrl} :
		a_sel == FDC_SEL_CMD ? {28'h0, status} :
		a_sel == FDC_SEL_TRACK ? {24'h0, track} :
		a_sel == FDC_SEL_SECTOR ? {24'h0, sector} : {24'h0, data};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hrdata <= '0;
		else if (bus_take && !hwrite) hrdata <= rd_mux;
	end

	// stepping rate lookup
	wire [31:0] step_period = cmd[1:0] == 2'h0 ? STEP_CYCLES_0 :
		cmd[1:0] == 2'h1 ? STEP_CYCLES_1 :
		cmd[1:0] == 2'h2 ? STEP_CYCLES_2 : STEP_CYCLES_3;
	wire is_pos = kind == FDC_K_POS;
	wire is_sec = kind == FDC_K_RSEC || kind == FDC_K_WSEC;
	wire step_dir_in = cmd[7:5] == 3'h2 || (cmd[7:4] == 4'h1 && target > track) ||
		(cmd[7:5] == 3'h1 && direction_out);
	wire at_target = cmd[7:5] == 3'h0 ? (cmd[4] ? target == track : !s_tr0[1]) : 1'b0;
	wire side_ok = !cmd[1] || id_q.side == cmd[3];
	wire id_match = s_idv[1] && id_q.track == track && (is_pos || side_ok);
	wire settle_go = head_engage_out && s_settled[1];
	wire new_cmd = cmd_wr && kind_new != FDC_K_FORCE;
	wire force_cmd = cmd_wr && kind_new == FDC_K_FORCE;
	wire cond_hit = (force_cond[0] && ready_rise) || (force_cond[1] && ready_fall) ||
		(force_cond[2] && index_rise);
	wire done_evt = state == FDC_DONE;
	wire hw_set = done_evt || cond_hit || (force_cmd && wbyte[3]);
	wire host_clr = cmd_wr || stat_rd;
	wire xfer_last = timer == 32'h0;
	wire byte_set = state == FDC_XFER && timer[2:0] == 3'h0 && !xfer_last;

	// command engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd <= FDC_CMD_RESET_VAL;
			sector <= FDC_SECTOR_RESET_VAL;
			track <= 8'h0;
			target <= 8'h0;
			data <= 8'h0;
			ctrl <= 8'h0;
			state <= FDC_IDLE;
			timer <= '0;
			revs <= 3'h0;
			force_cond <= 4'h0;
			seek_error <= 1'b0;
			record_missing_flag <= 1'b0;
			boot_restore <= 1'b1;
			stepped <= 1'b0;
			head_engage_out <= 1'b0;
			inner_track_out <= 1'b0;
			step_out <= 1'b0;
			direction_out <= 1'b0;
			data_mark_out <= FDC_MARK_NORMAL;
		end else begin
			boot_restore <= 1'b0;
			if (wr_now && ctrl_hit) ctrl <= wbyte;
			if (wr_now && !ctrl_hit && reg_sel == FDC_SEL_TRACK) track <= wbyte;
			if (wr_now && !ctrl_hit && reg_sel == FDC_SEL_SECTOR) sector <= wbyte;
			if (wr_now && !ctrl_hit && reg_sel == FDC_SEL_DATA) begin
				data <= wbyte;
				target <= wbyte;
			end
			if (force_cmd) begin
				force_cond <= wbyte[3:0];
				state <= FDC_IDLE;
				step_out <= 1'b0;
			end else if (boot_restore || new_cmd) begin
				if (new_cmd) cmd <= wbyte;
				force_cond <= 4'h0;
				seek_error <= 1'b0;
				record_missing_flag <= 1'b0;
				stepped <= 1'b0;
				state <= FDC_HEAD;
			end else begin
				case (state)
				FDC_HEAD: begin
					timer <= SETTLE_CYCLES;
					if (is_pos) begin
						head_engage_out <= cmd[3];
						timer <= step_period;
						state <= FDC_STEP;
					end else begin
						head_engage_out <= 1'b1;
						if (!cmd[2]) timer <= '0;
						state <= FDC_SETTLE;
					end
				end
				FDC_SETTLE: begin
					if (timer != 32'h0) timer <= timer - 32'h1;
					else if (settle_go) begin
						inner_track_out <= track >= FDC_INNER_TRACK;
						revs <= 3'h0;
						state <= is_pos ? FDC_VERIFY : FDC_SEARCH;
					end
				end
				FDC_STEP: begin
					if (timer != 32'h0) begin
						timer <= timer - 32'h1;
						if (timer == 32'h1) step_out <= 1'b0;
					end else if (at_target || (cmd[7:5] != 3'h0 && stepped)) begin
						if (cmd[7:4] == 4'h0) track <= 8'h0;
						if (cmd[2]) begin
							head_engage_out <= 1'b1;
							timer <= '0;
							state <= FDC_SETTLE;
						end else state <= FDC_DONE;
					end else begin
						direction_out <= step_dir_in;
						step_out <= 1'b1;
						stepped <= 1'b1;
						timer <= step_period;
						if (cmd[7:4] == 4'h1 || cmd[7:4] == 4'h0) begin
							track <= step_dir_in ? track + 8'h1 : track - 8'h1;
						end else if (cmd[4]) begin
							track <= step_dir_in ? track + 8'h1 : track - 8'h1;
						end
					end
				end
				FDC_VERIFY, FDC_SEARCH: begin
					if (id_match && (state == FDC_VERIFY || id_q.track == track)) begin
						if (state == FDC_VERIFY) state <= FDC_DONE;
						else begin
							data_mark_out <= cmd[0] ? FDC_MARK_DELETED : FDC_MARK_NORMAL;
							timer <= FDC_XFER_CYCLES;
							state <= FDC_XFER;
						end
					end else if (index_rise) begin
						revs <= revs + 3'h1;
						if (revs + 3'h1 == FDC_MAX_REVS) begin
							if (state == FDC_VERIFY) seek_error <= 1'b1;
							else record_missing_flag <= 1'b1;
							state <= FDC_DONE;
						end
					end
				end
				FDC_XFER: begin
					if (!xfer_last) timer <= timer - 32'h1;
					else if (is_sec && cmd[4]) begin
						sector <= sector + 8'h1;
						revs <= 3'h0;
						state <= FDC_SEARCH;
					end else state <= FDC_DONE;
				end
				FDC_DONE: state <= FDC_IDLE;
				default: state <= FDC_IDLE;
				endcase
			end
		end
	end

	// request flags: hardware set wins over host clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			command_irq <= 1'b0;
			byte_request <= 1'b0;
		end else begin
			command_irq <= hw_set || (command_irq && !host_clr);
			byte_request <= byte_set || (byte_request && !data_acc);
		end
	end
endmodule

/* fdc_pkg.sv */
// shared constants, types and register map for the floppy command decoder
package fdc_pkg;
	localparam logic [31:0] FDC_REG_STATUS_CMD = 32'h0000_0000;
	localparam logic [31:0] FDC_REG_TRACK = 32'h0000_0004;
	localparam logic [31:0] FDC_REG_SECTOR = 32'h0000_0008;
	localparam logic [31:0] FDC_REG_DATA = 32'h0000_000c;
	localparam logic [31:0] FDC_REG_CTRL = 32'h0000_0010;
	localparam logic [1:0] FDC_SEL_CMD = 2'h0;
	localparam logic [1:0] FDC_SEL_TRACK = 2'h1;
	localparam logic [1:0] FDC_SEL_SECTOR = 2'h2;
	localparam logic [1:0] FDC_SEL_DATA = 2'h3;
	localparam logic [7:0] FDC_CMD_RESET_VAL = 8'h03;
	localparam logic [7:0] FDC_SECTOR_RESET_VAL = 8'h01;
	localparam logic [7:0] FDC_MARK_DELETED = 8'hf8;
	localparam logic [7:0] FDC_MARK_NORMAL = 8'hfb;
	localparam logic [7:0] FDC_INNER_TRACK = 8'h2c;
	localparam logic [2:0] FDC_MAX_REVS = 3'h6;
	localparam int FDC_CLK_MHZ = 250;
	localparam int FDC_SETTLE_MS = 15;
	localparam int FDC_SETTLE_CYCLES = FDC_SETTLE_MS * 1000 * FDC_CLK_MHZ;
	localparam int FDC_STEP_US_0 = 6;
	localparam int FDC_STEP_US_1 = 12;
	localparam int FDC_STEP_US_2 = 20;
	localparam int FDC_STEP_US_3 = 30;
	localparam int FDC_XFER_CYCLES = 16;
	typedef enum logic [3:0] {
		FDC_IDLE = 4'h0,
		FDC_HEAD = 4'h1,
		FDC_SETTLE = 4'h2,
		FDC_STEP = 4'h3,
		FDC_VERIFY = 4'h4,
		FDC_SEARCH = 4'h5,
		FDC_XFER = 4'h6,
		FDC_DONE = 4'h7
	} fdc_state_t;
	typedef enum logic [2:0] {
		FDC_K_POS = 3'h0,
		FDC_K_RSEC = 3'h1,
		FDC_K_WSEC = 3'h2,
		FDC_K_RADDR = 3'h3,
		FDC_K_RTRK = 3'h4,
		FDC_K_WTRK = 3'h5,
		FDC_K_FORCE = 3'h6,
		FDC_K_BAD = 3'h7
	} fdc_kind_t;
	typedef struct packed {
		logic [7:0] track;
		logic side;
	} fdc_id_t;
	typedef struct packed {
		logic busy;
		logic record_missing_flag;
		logic seek_error;
		logic byte_request;
	} fdc_status_t;
endpackage

/* fdc_props.sv */
// assertion checker for the floppy command decoder ports
`timescale 1ns/1ps
module fdc_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic step_out,
	input wire logic [7:0] data_mark_out,
	input wire logic command_irq
);
	logic pend;
	wire acc0 = hsel && htrans[1] && hready && haddr[7:0] == 8'h00;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend <= 1'b0;
		else
			pend <= acc0 && hwrite;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_mark_legal: assert property (data_mark_out inside {8'hf8, 8'hfb})
		else $error("bad data mark");
	chk_irq_clear_cause: assert property ($fell(command_irq) |->
		$past(acc0) || $past(acc0, 2) || $past(acc0, 3))
		else $error("irq cleared without access");
	chk_force_irq_now: assert property (pend && hwdata[7:3] == 5'h1b |=> ##[0:2] command_irq)
		else $error("immediate force gave no irq");
	chk_force_zero_quiet: assert property (pend && hwdata[7:0] == 8'hd0 |=> !command_irq [*3])
		else $error("silent force raised irq");
	chk_step_width: assert property ($rose(step_out) |=> step_out [*3])
		else $error("step pulse too short");
endmodule

/* fdc_drive_model.sv */
// behavioural floppy drive facing the decoder
`timescale 1ns/1ps
module fdc_drive_model (
	input wire logic hclk,
	input wire logic head_engage_out,
	input wire logic step_out,
	input wire logic direction_out,
	input wire logic id_off,
	output logic index_hole_in,
	output logic head_settled_in,
	output logic track_zero_n_in,
	output logic id_valid_in,
	output logic [8:0] id_field_in
);
	logic [5:0] cnt = 6'h00;
	logic [7:0] pos = 8'h03;
	logic [2:0] hd = 3'h0;
	logic step_d = 1'b0;
	wire win = cnt >= 6'h10 && cnt < 6'h20;
	assign index_hole_in = cnt < 6'h04;
	assign track_zero_n_in = pos != 8'h00;
	assign head_settled_in = hd[2];
	always @(posedge hclk) begin
		cnt <= cnt + 6'h01;
		step_d <= step_out;
		hd <= {hd[1:0], head_engage_out};
		if (step_out && !step_d)
			pos <= direction_out ? pos + 8'h01 : pos - 8'h01;
		id_valid_in <= cnt >= 6'h14 && cnt < 6'h18;
		// off-track id on demand; field toggles outside its window
		if (win)
			id_field_in <= {pos + {7'h0, id_off}, 1'b0};
		else
			id_field_in <= ~id_field_in;
	end
endmodule

/* tb.sv */
// self-checking bench for the floppy command decoder
`timescale 1ns/1ps
module tb import fdc_pkg::*; ;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, v, s;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, op;
	logic drive_ready_in = 1'b1, density_select_n = 1'b1, id_off = 1'b0, h;
	logic [7:0] t;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, head_engage_out, step_out, direction_out, byte_request;
	wire logic command_irq, index_hole_in, head_settled_in, track_zero_n_in, id_valid_in;
	wire logic [8:0] id_field_in;
	wire logic [7:0] data_mark_out;
	wire logic inner_track_out;
	int failures = 0, checked = 0, cyc = 0, i, n, seed = 32'hde2bb7d9;
	fdc_command_decoder #(.SETTLE_CYCLES(20), .STEP_CYCLES_0(4), .STEP_CYCLES_1(5),
		.STEP_CYCLES_2(6), .STEP_CYCLES_3(8)) i_dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.drive_ready_in, .index_hole_in, .head_settled_in, .track_zero_n_in, .id_valid_in,
		.id_field_in, .density_select_n, .head_engage_out, .inner_track_out, .step_out,
		.direction_out, .data_mark_out, .byte_request, .command_irq);
	fdc_drive_model i_drive (.hclk, .head_engage_out, .step_out, .direction_out, .id_off,
		.index_hole_in, .head_settled_in, .track_zero_n_in, .id_valid_in, .id_field_in);
	initial forever #2 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 80000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test;
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		density_select_n <= $random(seed);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic run(input logic [7:0] c, output logic [31:0] st, output logic hl);
		wr(FDC_REG_STATUS_CMD, {24'h0, c});
		repeat (3) @(posedge hclk);
		hl = head_engage_out;
		do @(posedge hclk); while (command_irq !== 1'b1);
		bus(1'b0, FDC_REG_STATUS_CMD, 32'h0, st);
	endtask
	function automatic logic [7:0] step_exp(logic [7:0] tr, logic upd, logic inward);
		return upd ? (inward ? tr + 8'h01 : tr - 8'h01) : tr;
	endfunction
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, FDC_REG_SECTOR, 0, v);
		chk("sector", {24'h0, FDC_SECTOR_RESET_VAL}, v);
		bus(1'b0, FDC_REG_STATUS_CMD, 0, v);
		chk("busy", 1, v[3]);
		do @(posedge hclk); while (command_irq !== 1'b1);
		bus(1'b0, FDC_REG_TRACK, 0, v);
		chk("track", 0, v);
		bus(1'b0, FDC_REG_STATUS_CMD, 0, v);
		@(posedge hclk);
		chk("irq", 0, command_irq);
		t = 8'($random(seed)) | 8'h01;
		wr(FDC_REG_TRACK, t);
		wr(32'h14, ~t);
		bus(1'b0, 32'h14, 0, v);
		chk("mirror", {24'h0, ~t}, v);
		for (i = 0; i < 5; i++) begin
			t = (8'($random(seed)) & 8'h3f) | 8'h01;
			op = (i == 4) ? 3'b001 : {2'b01, i[1]};
			wr(FDC_REG_TRACK, t);
			run({op, i[0] && i != 4, 2'b00, 2'(i)}, v, h);
			bus(1'b0, FDC_REG_TRACK, 0, v);
			chk("track", step_exp(t, i[0] && i != 4, op == 3'b010), v);
			chk("head", 0, h | head_engage_out);
		end
		run(8'h03, v, h);
		for (i = 0; i < 2; i++) begin
			id_off <= i[0];
			wr(FDC_REG_DATA, 5 + 4 * i);
			run(8'h1c, v, h);
			chk("head", 1, h);
			chk("seek err", i[0], v[1]);
		end
		bus(1'b0, FDC_REG_TRACK, 0, v);
		chk("track", 9, v);
		id_off <= 1'b0;
		for (i = 0; i < 7; i++) begin
			t = i < 2 ? 8'ha0 | 8'(i) : i == 2 ? 8'h8a : i == 3 ? 8'h86 : i == 4 ? 8'hc4 :
				i == 5 ? 8'he4 : 8'hf4;
			run(t, v, h);
			chk("missing", i == 2, v[2]);
			if (i < 2)
				chk("mark", i ? FDC_MARK_DELETED : FDC_MARK_NORMAL, data_mark_out);
			chk("inner", 0, inner_track_out);
		end
		wr(FDC_REG_STATUS_CMD, 8'h80);
		do @(posedge hclk); while (byte_request !== 1'b1);
		bus(1'b0, FDC_REG_DATA, 0, v);
		@(posedge hclk);
		chk("byte req", 0, byte_request);
		do @(posedge hclk); while (command_irq !== 1'b1);
		t = 8'($random(seed)) & 8'h3f;
		wr(FDC_REG_SECTOR, t);
		wr(FDC_REG_STATUS_CMD, 8'h90);
		repeat (300) @(posedge hclk);
		wr(FDC_REG_STATUS_CMD, 8'hd0);
		bus(1'b0, FDC_REG_SECTOR, 0, v);
		chk("multi", 1, v[7:0] > t);
		id_off <= 1'b1;
		run(8'h90, v, h);
		chk("missing", 1, v[2]);
		drive_ready_in <= 1'b0;
		repeat (4) @(posedge hclk);
		for (i = 0; i < 4; i++) begin
			wr(FDC_REG_STATUS_CMD, 8'hd0 | (8'h01 << i));
			drive_ready_in <= (i != 1);
			for (n = 0; n < 100 && command_irq !== 1'b1; n++) @(posedge hclk);
			chk("force irq", 1, command_irq);
			wr(FDC_REG_STATUS_CMD, 8'hd0);
			@(posedge hclk);
			chk("irq", 0, command_irq);
		end
		stop_test();
	end
endmodule
bind fdc_command_decoder fdc_props i_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .step_out, .data_mark_out,
	.command_irq);
